// ### rtl/acbuf_pkg.sv
// Purpose: Shared constants and types of the acceleration sample buffer
// Assumes: 32-bit AHB-Lite register bus, word access only
// Notes:   Offsets are byte addresses
package acbuf_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ACBUF_OFS_CTRL     = 8'h00;
  localparam logic [7:0] ACBUF_OFS_THRESH   = 8'h04;
  localparam logic [7:0] ACBUF_OFS_STATUS   = 8'h08;
  localparam logic [7:0] ACBUF_OFS_INT_STAT = 8'h0c;
  localparam logic [7:0] ACBUF_OFS_INT_MASK = 8'h10;
  localparam logic [7:0] ACBUF_OFS_DATA     = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ACBUF_CTRL_MODE_LSB = 0;
  localparam int ACBUF_CTRL_RES_BIT  = 2;
  localparam int ACBUF_CTRL_EN_BIT   = 3;
  localparam int ACBUF_CTRL_CLR_BIT  = 4;
  localparam int ACBUF_STAT_CNT_LSB  = 0;
  localparam int ACBUF_STAT_CNT_W    = 10;
  localparam int ACBUF_STAT_WM_BIT   = 10;
  localparam int ACBUF_STAT_EXTERNAL_TRIGGER_INPUT_BIT = 11;
  localparam int ACBUF_STAT_FULL_BIT = 12;
  localparam int ACBUF_STAT_ARMD_BIT = 13;
  localparam int ACBUF_IRQ_WM        = 0;
  localparam int ACBUF_IRQ_EXTERNAL_TRIGGER_INPUT      = 1;
  localparam int ACBUF_IRQ_FULL      = 2;
  localparam int ACBUF_N_IRQ         = 3;

  // ----------------------------------------------------------------
  // Sample layout and reset values
  // ----------------------------------------------------------------
  localparam int         ACBUF_AXIS_W      = 16;
  localparam int         ACBUF_SLOT_W      = 48;
  localparam logic [2:0] ACBUF_LAST_BYTE_HI = 3'h5;
  localparam logic [2:0] ACBUF_LAST_BYTE_LO = 3'h2;
  localparam logic [7:0] ACBUF_THRESH_RST  = 8'h00;
  localparam logic [ACBUF_N_IRQ-1:0] ACBUF_MASK_RST = 3'h0;
  localparam logic [1:0] ACBUF_HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    ACBUF_MODE_FIFO,
    ACBUF_MODE_STREAM,
    ACBUF_MODE_TRIGGER
  } acbuf_mode_t;

  typedef struct packed {
    logic [ACBUF_AXIS_W-1:0] z;
    logic [ACBUF_AXIS_W-1:0] y;
    logic [ACBUF_AXIS_W-1:0] x;
  } acbuf_sample_t;

endpackage

// ### rtl/acbuf_sticky_bit.sv
// Purpose: One sticky interrupt status bit, cleared by writing a one
// Assumes: set and clr are single-cycle requests
// Notes:   Set wins over a clear in the same cycle
`timescale 1ns/1ps
module acbuf_sticky_bit (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);

  typedef struct packed {
    logic flag;
  } acbuf_sticky_t;

  acbuf_sticky_t st_r;
  acbuf_sticky_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (set) begin
      st_nxt.flag = 1'b1;
    end else if (clr) begin
      st_nxt.flag = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.flag;

endmodule

// ### rtl/acbuf_sample_store.sv
// Purpose: Flip-flop storage of sample slots, six bytes per slot
// Assumes: One write per cycle, read is combinational by index
// Notes:   Byte 0 of a slot is the first byte read out
`timescale 1ns/1ps
module acbuf_sample_store
  import acbuf_pkg::*;
#(
  parameter int CAP   = 32,
  parameter int PTR_W = 5
) (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    wr_en,
  input  wire logic [PTR_W-1:0]        wr_idx,
  input  wire logic [ACBUF_SLOT_W-1:0] wr_data,
  input  wire logic [PTR_W-1:0]        rd_idx,
  output logic      [ACBUF_SLOT_W-1:0] rd_data
);

  typedef struct packed {
    logic [CAP-1:0][ACBUF_SLOT_W-1:0] slot;
  } acbuf_store_t;

  acbuf_store_t st_r;
  acbuf_store_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (wr_en) begin
      st_nxt.slot[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.slot[rd_idx];

endmodule

// ### rtl/acbuf_top.sv
// Purpose: Acceleration sample buffer with FIFO, stream and trigger modes
// Assumes: Samples arrive as one-cycle pulses at the output data rate
// Notes:   Registers over AHB-Lite, one wait state on every transfer
//
// Function
// - Each sample is stored as a run of bytes in sequence, six bytes in high resolution.
// - The write pointer names the slot for the next sample and steps one slot per stored sample.
// - In FIFO and stream mode the watermark rises when the stored count reaches the threshold.
// - In trigger mode before a trigger, a new sample at or above threshold drops the oldest one.
// - After a trigger, no more dropping; samples append until full, then collection stops.
// - A finished capture holds threshold samples from before the trigger and the rest after it.
// - FIFO mode, and trigger mode after a trigger, accept no sample while every slot is occupied.
// - Stream mode, when full, replaces the oldest sample with each new one.
// - Reading a sample removes the oldest one and lowers the count by one.
// - Samples are stored with 8 bits per axis in low resolution or 16 bits in high resolution.
// - The watermark stays high until the count falls below the threshold.
// - A trigger is a physical interrupt from a motion engine or a high external trigger input.
// - The trigger-captured flag sets on a physical interrupt with at least threshold samples stored.
//
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module acbuf_top
  import acbuf_pkg::*;
#(
  parameter int CAP = 32
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  input  wire logic          sample_valid,
  input  wire acbuf_sample_t sample_in,
  input  wire logic          phys_int,
  input  wire logic          external_trigger_input,
  output logic               watermark,
  output logic               trigger_captured_flag,
  output logic               irq
);

  // ----------------------------------------------------------------
  // Sizes and checks
  // ----------------------------------------------------------------
  localparam int PTR_W = $clog2(CAP);
  localparam int CNT_W = $clog2(CAP + 1);

  initial begin
    if (CAP < 2 || CAP > 1023) begin
      $error("acbuf_top: CAP must lie in 2..1023");
    end
  end

  typedef struct packed {
    logic                   ph_valid;
    logic                   ph_wait;
    logic                   ph_write;
    logic [7:0]             ph_addr;
    logic [31:0]            rdata;
    acbuf_mode_t            mode;
    logic                   res_hi;
    logic                   enable;
    logic [7:0]             th;
    logic [ACBUF_N_IRQ-1:0] mask;
    logic [PTR_W-1:0]       wr_ptr;
    logic [PTR_W-1:0]       rd_ptr;
    logic [CNT_W-1:0]       count;
    logic [2:0]             byte_idx;
    logic                   triggered;
    logic                   external_trigger_input_flag;
    logic                   wm;
    logic                   full_d;
  } acbuf_state_t;

  acbuf_state_t st_r;
  acbuf_state_t st_nxt;

  logic [ACBUF_SLOT_W-1:0] slot_rd;
  logic [ACBUF_SLOT_W-1:0] slot_wr;
  logic                    wr_en;
  logic [ACBUF_N_IRQ-1:0]  irq_set;
  logic [ACBUF_N_IRQ-1:0]  irq_clr;
  logic [ACBUF_N_IRQ-1:0]  irq_stat;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    if (p == PTR_W'(CAP - 1)) begin
      return '0;
    end
    return p + PTR_W'(1);
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  acbuf_sample_store #(
    .CAP   (CAP),
    .PTR_W (PTR_W)
  ) u_store (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (wr_en),
    .wr_idx  (st_r.wr_ptr),
    .wr_data (slot_wr),
    .rd_idx  (st_r.rd_ptr),
    .rd_data (slot_rd)
  );

  // ----------------------------------------------------------------
  // Sticky interrupt status
  // ----------------------------------------------------------------
  for (genvar i = 0; i < ACBUF_N_IRQ; i++) begin : g_irq
    acbuf_sticky_bit u_bit (
      .hclk    (hclk),
      .hresetn (hresetn),
      .set     (irq_set[i]),
      .clr     (irq_clr[i]),
      .q       (irq_stat[i])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [15:0]      eff_th;
  logic [15:0]      eff_th_new;
  logic [15:0]      cnt16;
  logic             full;
  logic             at_th;
  logic             bus_do;
  logic             rd_data_acc;
  logic             pop;
  logic             push;
  logic             drop;
  logic             clear;
  logic [2:0]       last_byte;
  logic [7:0]       rd_byte;
  logic [CNT_W-1:0] cnt_new;
  logic             wm_new;
  logic             full_new;

  always_comb begin
    st_nxt      = st_r;
    wr_en       = 1'b0;
    push        = 1'b0;
    drop        = 1'b0;
    clear       = 1'b0;
    irq_set     = '0;
    irq_clr     = '0;
    // Threshold above capacity is clamped, so a full buffer still meets it
    cnt16       = 16'(st_r.count);
    eff_th      = ({8'h00, st_r.th} > 16'(CAP)) ? 16'(CAP) : {8'h00, st_r.th};
    full        = (st_r.count == CNT_W'(CAP));
    at_th       = (eff_th != 16'h0000) && (cnt16 >= eff_th);
    last_byte   = st_r.res_hi ? ACBUF_LAST_BYTE_HI : ACBUF_LAST_BYTE_LO;
    rd_byte     = slot_rd[{st_r.byte_idx, 3'h0} +: 8];
    // Bus work happens in the wait-state cycle of the data phase
    bus_do      = st_r.ph_valid && st_r.ph_wait;
    rd_data_acc = bus_do && !st_r.ph_write && (st_r.ph_addr == ACBUF_OFS_DATA);
    pop         = rd_data_acc && (st_r.count != '0) && (st_r.byte_idx == last_byte);

    // Low resolution keeps the upper byte of each axis, packed in sequence
    if (st_r.res_hi) begin
      slot_wr = {sample_in.z, sample_in.y, sample_in.x};
    end else begin
      slot_wr = {24'h000000, sample_in.z[15:8], sample_in.y[15:8], sample_in.x[15:8]};
    end

    // Sample collection
    if (sample_valid && st_r.enable) begin
      case (st_r.mode)
        ACBUF_MODE_STREAM: begin
          push = 1'b1;
          drop = full && !pop;
        end
        ACBUF_MODE_TRIGGER: begin
          if (st_r.triggered) begin
            push = !full;
          end else if (eff_th != 16'h0000) begin
            push = 1'b1;
            drop = at_th && !pop;
          end
        end
        default: begin
          push = !full;
        end
      endcase
    end
    if (full && pop && st_r.mode != ACBUF_MODE_STREAM && sample_valid && st_r.enable) begin
      push = 1'b0;
    end
    wr_en = push;

    // Pointers and count
    if (push) begin
      st_nxt.wr_ptr = ptr_inc(st_r.wr_ptr);
    end
    if (pop || drop) begin
      st_nxt.rd_ptr   = ptr_inc(st_r.rd_ptr);
      st_nxt.byte_idx = 3'h0;
    end else if (rd_data_acc && st_r.count != '0) begin
      st_nxt.byte_idx = st_r.byte_idx + 3'h1;
    end
    cnt_new = st_r.count;
    if (push && !(pop || drop)) begin
      cnt_new = st_r.count + CNT_W'(1);
    end else if (!push && (pop || drop)) begin
      cnt_new = st_r.count - CNT_W'(1);
    end
    st_nxt.count = cnt_new;

    // Trigger detection
    if (st_r.mode == ACBUF_MODE_TRIGGER && !st_r.triggered && (phys_int || external_trigger_input)) begin
      st_nxt.triggered = 1'b1;
    end
    if (st_r.mode == ACBUF_MODE_TRIGGER && phys_int && (cnt16 >= eff_th) && !st_r.external_trigger_input_flag) begin
      st_nxt.external_trigger_input_flag = 1'b1;
      irq_set[ACBUF_IRQ_EXTERNAL_TRIGGER_INPUT] = 1'b1;
    end

    // Register reads and writes
    if (bus_do) begin
      st_nxt.ph_wait = 1'b0;
      if (st_r.ph_write) begin
        case (st_r.ph_addr)
          ACBUF_OFS_CTRL: begin
            case (hwdata[ACBUF_CTRL_MODE_LSB +: 2])
              2'h1:    st_nxt.mode = ACBUF_MODE_STREAM;
              2'h2:    st_nxt.mode = ACBUF_MODE_TRIGGER;
              default: st_nxt.mode = ACBUF_MODE_FIFO;
            endcase
            st_nxt.res_hi = hwdata[ACBUF_CTRL_RES_BIT];
            st_nxt.enable = hwdata[ACBUF_CTRL_EN_BIT];
            clear         = hwdata[ACBUF_CTRL_CLR_BIT];
          end
          ACBUF_OFS_THRESH:   st_nxt.th   = hwdata[7:0];
          ACBUF_OFS_INT_STAT: irq_clr     = hwdata[ACBUF_N_IRQ-1:0];
          ACBUF_OFS_INT_MASK: st_nxt.mask = hwdata[ACBUF_N_IRQ-1:0];
          default: begin
          end
        endcase
      end else begin
        case (st_r.ph_addr)
          ACBUF_OFS_CTRL: begin
            st_nxt.rdata = {27'h0000000, 1'b0, st_r.enable, st_r.res_hi, st_r.mode};
          end
          ACBUF_OFS_THRESH:   st_nxt.rdata = {24'h000000, st_r.th};
          ACBUF_OFS_STATUS: begin
            st_nxt.rdata = '0;
            st_nxt.rdata[ACBUF_STAT_CNT_LSB +: ACBUF_STAT_CNT_W] = ACBUF_STAT_CNT_W'(st_r.count);
            st_nxt.rdata[ACBUF_STAT_WM_BIT]   = st_r.wm;
            st_nxt.rdata[ACBUF_STAT_EXTERNAL_TRIGGER_INPUT_BIT] = st_r.external_trigger_input_flag;
            st_nxt.rdata[ACBUF_STAT_FULL_BIT] = full;
            st_nxt.rdata[ACBUF_STAT_ARMD_BIT] = st_r.triggered;
          end
          ACBUF_OFS_INT_STAT: st_nxt.rdata = {29'h00000000, irq_stat};
          ACBUF_OFS_INT_MASK: st_nxt.rdata = {29'h00000000, st_r.mask};
          // Empty buffer reads zero and removes nothing
          ACBUF_OFS_DATA: st_nxt.rdata = (st_r.count != '0) ? {24'h000000, rd_byte} : 32'h00000000;
          default:            st_nxt.rdata = 32'h00000000;
        endcase
      end
    end else if (st_r.ph_valid && hready) begin
      st_nxt.ph_valid = 1'b0;
    end

    // Address phase capture, only while the bus is ready
    if (hready && hreadyout && hsel && htrans == ACBUF_HTRANS_NONSEQ) begin
      st_nxt.ph_valid = 1'b1;
      st_nxt.ph_wait  = 1'b1;
      st_nxt.ph_write = hwrite;
      st_nxt.ph_addr  = haddr[7:0];
    end

    // Clear overrides any collection in the same cycle
    if (clear) begin
      wr_en            = 1'b0;
      st_nxt.wr_ptr    = '0;
      st_nxt.rd_ptr    = '0;
      st_nxt.count     = '0;
      st_nxt.byte_idx  = 3'h0;
      st_nxt.triggered = 1'b0;
      st_nxt.external_trigger_input_flag = 1'b0;
    end

    // Watermark level and edge events, against the threshold of the same edge
    eff_th_new = ({8'h00, st_nxt.th} > 16'(CAP)) ? 16'(CAP) : {8'h00, st_nxt.th};
    wm_new   = (st_nxt.mode != ACBUF_MODE_TRIGGER) && (eff_th_new != 16'h0000)
               && (16'(st_nxt.count) >= eff_th_new);
    full_new = (st_nxt.count == CNT_W'(CAP));
    st_nxt.wm     = wm_new;
    st_nxt.full_d = full_new;
    if (wm_new && !st_r.wm) begin
      irq_set[ACBUF_IRQ_WM] = 1'b1;
    end
    if (full_new && !st_r.full_d) begin
      irq_set[ACBUF_IRQ_FULL] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r      <= '0;
      st_r.mode <= ACBUF_MODE_FIFO;
      st_r.th   <= ACBUF_THRESH_RST;
      st_r.mask <= ACBUF_MASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout             = !(st_r.ph_valid && st_r.ph_wait);
  assign hresp                 = 1'b0;
  assign hrdata                = st_r.rdata;
  assign watermark             = st_r.wm;
  assign trigger_captured_flag = st_r.external_trigger_input_flag;
  // Level output, low as soon as software clears or masks the cause
  assign irq                   = |(irq_stat & st_r.mask);

endmodule

// ### verif/acbuf_props.sv
// Purpose: Port-level assertions for the sample buffer top
// Assumes: Single clock, async active-low reset
// Notes:   Bound to acbuf_top below the module
`timescale 1ns/1ps
module acbuf_props
  import acbuf_pkg::*;
#(
  parameter int CAP = 32
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        sample_valid,
  input wire logic        phys_int,
  input wire logic        watermark,
  input wire logic        trigger_captured_flag,
  input wire logic        irq
);
  // ----------------------------------------------------------------
  // Data phase tracking
  // ----------------------------------------------------------------
  logic taken;
  logic ph_r;
  logic rd_r;
  assign taken = hsel && (htrans == ACBUF_HTRANS_NONSEQ) && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_r <= 1'b0;
      rd_r <= 1'b0;
    end else begin
      ph_r <= taken;
      rd_r <= taken && !hwrite;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_one_wait: assert property (taken |=> !hreadyout ##1 hreadyout)
    else $error("wait state not exactly one cycle");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_rdata_holds: assert property ($changed(hrdata) |-> $past(rd_r))
    else $error("read data moved outside a read");
  chk_wm_rise: assert property ($rose(watermark) |-> $past(sample_valid || ph_r))
    else $error("watermark rose without a sample");
  chk_wm_fall: assert property ($fell(watermark) |-> $past(ph_r))
    else $error("watermark fell without a bus access");
  chk_irq_cause: assert property ($rose(irq) |-> $past(sample_valid || phys_int || ph_r))
    else $error("interrupt rose without an event");
  chk_external_trigger_input_cause: assert property ($rose(trigger_captured_flag) |-> $past(phys_int))
    else $error("capture flag set without physical interrupt");
  chk_external_trigger_input_sticky: assert property ($fell(trigger_captured_flag) |-> $past(ph_r))
    else $error("capture flag dropped without a clear");
endmodule

bind acbuf_top acbuf_props #(.CAP(CAP)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .sample_valid(sample_valid), .phys_int(phys_int), .watermark(watermark),
  .trigger_captured_flag(trigger_captured_flag), .irq(irq)
);

// ### verif/acbuf_host.sv
// Purpose: Host controller model, single AHB-Lite word transfers
// Assumes: One slave, its hreadyout is hready
// Notes:   Waits are bounded; a stuck slave raises hang
`timescale 1ns/1ps
module acbuf_host
  import acbuf_pkg::*;
(
  input  wire logic   hclk,
  input  wire logic   hready,
  output logic        hsel,
  output logic [31:0] haddr,
  output logic [1:0]  htrans,
  output logic        hwrite,
  output logic [2:0]  hsize,
  output logic [31:0] hwdata,
  output logic        hang
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hang = 1'b0;
  end
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) hang <= 1'b1;
  endtask
  // Request held until ready is seen high at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= ACBUF_HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask
endmodule

// ### verif/accel_sample_buffer_tb_top.sv
// Purpose: Self-checking bench for the sample buffer
// Assumes: Reference queue model of stored samples
// Notes:   Small capacity keeps full-buffer cases short
`timescale 1ns/1ps
module accel_sample_buffer_tb_top;
  import acbuf_pkg::*;
  localparam int CAP = 8;
  logic          hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, hang, rd_pend;
  logic [31:0]   haddr, hwdata, hrdata;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic          sample_valid, phys_int, external_trigger_input, watermark, trigger_captured_flag, irq;
  acbuf_sample_t sample_in;
  acbuf_sample_t mdl[$];
  logic [31:0]   exp_q[$];
  int            n_mismatch, comparisons, seed, mode_m, th_m;
  bit            external_trigger_input_m, tcap_m, res_m;
  assign hready = hreadyout;

  acbuf_host u_host (.hclk(hclk), .hready(hready), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hang(hang));
  acbuf_top #(.CAP(CAP)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_valid(sample_valid),
    .sample_in(sample_in), .phys_int(phys_int), .external_trigger_input(external_trigger_input),
    .watermark(watermark), .trigger_captured_flag(trigger_captured_flag), .irq(irq));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (exp_q.size() != 0) n_mismatch++;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Read results are matched against the oldest note
  always @(posedge hclk) begin
    if (rd_pend && hreadyout) begin
      rd_pend <= 1'b0;
      if (exp_q.size() == 0) n_mismatch++;
      else check(hrdata, exp_q.pop_front());
    end
    if (hsel && htrans == ACBUF_HTRANS_NONSEQ && hready && !hwrite) rd_pend <= 1'b1;
  end
  always @(posedge hang) begin
    n_mismatch++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Drivers and reference model
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b0, a, 32'h0);
  endtask
  function automatic logic [31:0] stat_exp();
    logic wm;
    wm = (mode_m != 2) && (th_m != 0) && (mdl.size() >= th_m);
    return {18'h0, external_trigger_input_m, mdl.size() == CAP, tcap_m, wm, 10'(mdl.size())};
  endfunction
  // Clear first so the threshold write never meets stale samples
  task automatic cfg(input int m, input bit r, input int th);
    mode_m = m;
    res_m = r;
    th_m = th;
    external_trigger_input_m = 1'b0;
    tcap_m = 1'b0;
    mdl.delete();
    wr(ACBUF_OFS_CTRL, {27'h0, 1'b1, 1'b1, r, 2'(m)});
    wr(ACBUF_OFS_THRESH, 32'(th));
    rd(ACBUF_OFS_STATUS, 32'h0);
  endtask
  task automatic send(input int n);
    acbuf_sample_t s;
    for (int i = 0; i < n; i++) begin
      s = 48'({$random(seed), $random(seed)});
      sample_valid <= 1'b1;
      sample_in <= s;
      if (mode_m == 2 && !external_trigger_input_m) begin
        if (th_m > 0 && mdl.size() >= th_m) void'(mdl.pop_front());
        if (th_m > 0) mdl.push_back(s);
      end else if (mode_m == 1 || mdl.size() < CAP) begin
        if (mdl.size() == CAP) void'(mdl.pop_front());
        mdl.push_back(s);
      end
      @(posedge hclk);
    end
    sample_valid <= 1'b0;
  endtask
  task automatic rd_sample();
    acbuf_sample_t s;
    logic [15:0]   w;
    s = mdl.pop_front();
    for (int i = 0; i < 3; i++) begin
      w = s[16*i +: 16];
      if (res_m) rd(ACBUF_OFS_DATA, {24'h0, w[7:0]});
      rd(ACBUF_OFS_DATA, {24'h0, w[15:8]});
    end
  endtask
  task automatic fire(input bit phys);
    phys_int <= phys;
    external_trigger_input <= !phys;
    @(posedge hclk);
    phys_int <= 1'b0;
    external_trigger_input <= 1'b0;
    external_trigger_input_m = 1'b1;
    if (phys && mdl.size() >= th_m) tcap_m = 1'b1;
    @(posedge hclk);
  endtask

  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    close_out();
  end
  initial begin
    seed = 32'hd9777591;
    hresetn = 1'b0;
    rd_pend = 1'b0;
    sample_valid = 1'b0;
    sample_in = '0;
    phys_int = 1'b0;
    external_trigger_input = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ACBUF_OFS_THRESH, {24'h0, ACBUF_THRESH_RST});
    rd(ACBUF_OFS_INT_MASK, 32'(ACBUF_MASK_RST));
    rd(8'h40, 32'h0);
    $display("test reset done");
    wr(ACBUF_OFS_INT_MASK, 32'h5);
    cfg(0, 1'b1, 5);
    send(3);
    rd(ACBUF_OFS_STATUS, stat_exp());
    check({31'h0, irq}, 32'h0);
    send(7);
    rd(ACBUF_OFS_STATUS, stat_exp());
    rd(ACBUF_OFS_INT_STAT, 32'h5);
    check({31'h0, irq}, 32'h1);
    wr(ACBUF_OFS_INT_STAT, 32'h7);
    check({31'h0, irq}, 32'h0);
    repeat (3) rd_sample();
    rd(ACBUF_OFS_STATUS, stat_exp());
    rd_sample();
    rd(ACBUF_OFS_STATUS, stat_exp());
    check({31'h0, watermark}, 32'h0);
    $display("test fifo done");
    cfg(1, 1'b0, 4);
    send(11);
    rd(ACBUF_OFS_STATUS, stat_exp());
    repeat (8) rd_sample();
    rd(ACBUF_OFS_DATA, 32'h0);
    $display("test stream done");
    cfg(2, 1'b1, 3);
    send(6);
    rd(ACBUF_OFS_STATUS, stat_exp());
    fire(1'b1);
    rd(ACBUF_OFS_STATUS, stat_exp());
    send(7);
    rd(ACBUF_OFS_STATUS, stat_exp());
    repeat (8) rd_sample();
    cfg(2, 1'b0, 2);
    check({31'h0, trigger_captured_flag}, 32'h0);
    send(4);
    fire(1'b0);
    send(3);
    rd(ACBUF_OFS_STATUS, stat_exp());
    repeat (5) rd_sample();
    $display("test trigger done");
    // Let the watcher take the last read before the queue is judged
    repeat (2) @(posedge hclk);
    close_out();
  end
endmodule
